// ===== inc/bms_defines.svh
`ifndef BMS_DEFINES_SVH
`define BMS_DEFINES_SVH
`define BMS_ADDR_W 24
`define BMS_USER_ENTRY 24'h000000
`define BMS_ALT_ENTRY 24'h090000
`define BMS_LOADER_ENTRY_DEF 24'h000000
`define BMS_SELECT_ENTRY_DEF 24'h000000
`define BMS_CAN_FILTER_CYC 5'h14
`define BMS_STRAP_USER 2'h3
`define BMS_STRAP_STD 2'h2
`define BMS_STRAP_ALT 2'h1
`define BMS_STRAP_RSVD 2'h0
`define BMS_CNT_W 5
`define BMS_RAM_AW 10
`define BMS_CNT_ONE 5'h01
`define BMS_CNT_ZERO 5'h00
`endif

// ===== inc/bms_pkg.sv
`include "bms_defines.svh"
package bms_pkg;
    typedef enum logic [5:0] {
        BMS_IDLE = 6'h01,
        BMS_USER = 6'h02,
        BMS_ALT = 6'h04,
        BMS_SCAN = 6'h08,
        BMS_UART = 6'h10,
        BMS_CAN = 6'h20
    } bms_state_t;

    typedef struct packed {
        logic [`BMS_ADDR_W-1:0] entry_addr;
        logic fetch_from_boot;
        logic soft_reset;
        logic watchdog_off;
        logic uart_tx_oe;
        logic can_tx_oe;
        logic selective;
        logic reserved_mode;
    } bms_boot_t;

    typedef struct packed {
        logic we;
        logic [`BMS_RAM_AW-1:0] addr;
        logic [7:0] data;
    } bms_ram_wr_t;
endpackage : bms_pkg

// ===== design/bms_boot_mode_selector.sv
`timescale 1ns/10ps
`default_nettype none
module bms_boot_mode_selector
    import bms_pkg::*;
#(
    parameter logic [`BMS_ADDR_W-1:0] LOADER_ENTRY = `BMS_LOADER_ENTRY_DEF,
    parameter logic [`BMS_ADDR_W-1:0] SELECT_ENTRY = `BMS_SELECT_ENTRY_DEF,
    parameter logic [`BMS_CNT_W-1:0] CAN_FILTER = `BMS_CAN_FILTER_CYC
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic reset_input_pin_in,
    input wire logic boot_select_upper_strap_in,
    input wire logic boot_select_lower_strap_in,
    input wire logic normal_reset_in,
    input wire logic user_sig_valid_in,
    input wire logic alt_sig_valid_in,
    input wire logic user_key_select_in,
    input wire logic loader_init_done_in,
    input wire logic uart0_receive_line_in,
    input wire logic can_port1_receive_line_in,
    input wire logic load_valid_in,
    input wire logic [7:0] load_data_in,
    output var bms_boot_t boot_out,
    output var bms_ram_wr_t ram_wr_out,
    output logic [1:0] straps_out,
    output logic decided_out
);
    logic rst_pin_d_reg;
    logic [1:0] strap_reg;
    logic latched_reg;
    bms_state_t state_reg;
    bms_state_t state_next;
    logic [`BMS_CNT_W-1:0] can_cnt_reg;
    logic [`BMS_CNT_W-1:0] can_cnt_next;
    logic can_hi_d_reg;
    logic uart_prev_reg;
    logic [`BMS_RAM_AW-1:0] ram_ptr_reg;
    logic [`BMS_ADDR_W-1:0] entry_reg;
    logic fetch_boot_reg;
    logic soft_reset_reg;
    logic watchdog_off_reg;
    logic uart_tx_oe_reg;
    logic can_tx_oe_reg;
    logic selective_reg;
    logic reserved_reg;
    logic decided_reg;
    logic pin_rise;
    logic can_rise;
    logic can_valid;
    logic uart_start;
    logic in_loader;
    logic link_up;
    logic alt_strap;
    logic no_signature;

    assign pin_rise = reset_input_pin_in && !rst_pin_d_reg;
    assign can_rise = can_port1_receive_line_in && !can_hi_d_reg;
    // A dominant bit counts only once it ends, so UART keeps priority while it lasts
    assign can_valid = can_rise && (can_cnt_reg == CAN_FILTER);
    assign uart_start = uart_prev_reg && !uart0_receive_line_in;
    assign link_up = (state_reg == BMS_UART) || (state_reg == BMS_CAN);
    assign in_loader = (state_reg == BMS_SCAN) || link_up;
    assign alt_strap = (strap_reg == `BMS_STRAP_ALT);
    assign no_signature = !user_sig_valid_in && !alt_sig_valid_in;

    // Straps sampled on the clock edge seeing the pin rise
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_pin_d_reg <= 1'b0;
        end else begin
            rst_pin_d_reg <= reset_input_pin_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            strap_reg <= `BMS_STRAP_RSVD;
            latched_reg <= 1'b0;
        end else if (pin_rise) begin
            strap_reg <= {boot_select_upper_strap_in, boot_select_lower_strap_in};
            latched_reg <= 1'b1;
        end
    end

    // Edge trackers reset to the idle level so reset gives no false edge
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            can_hi_d_reg <= 1'b1;
            uart_prev_reg <= 1'b1;
        end else begin
            can_hi_d_reg <= can_port1_receive_line_in;
            uart_prev_reg <= uart0_receive_line_in;
        end
    end

    // Dominant run length, saturating at the filter length
    always_comb begin
        can_cnt_next = can_cnt_reg;
        if (can_port1_receive_line_in) begin
            can_cnt_next = `BMS_CNT_ZERO;
        end else if (can_cnt_reg != CAN_FILTER) begin
            can_cnt_next = can_cnt_reg + `BMS_CNT_ONE;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            can_cnt_reg <= `BMS_CNT_ZERO;
        end else begin
            can_cnt_reg <= can_cnt_next;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BMS_IDLE: begin
                if (latched_reg) begin
                    case (strap_reg)
                        `BMS_STRAP_USER: state_next = BMS_USER;
                        `BMS_STRAP_STD: state_next = BMS_SCAN;
                        `BMS_STRAP_ALT: begin
                            if (user_sig_valid_in) begin
                                state_next = BMS_USER;
                            end else if (alt_sig_valid_in) begin
                                state_next = BMS_ALT;
                            end else begin
                                state_next = BMS_SCAN;
                            end
                        end
                        default: state_next = BMS_IDLE;
                    endcase
                end
            end
            BMS_SCAN: begin
                // UART wins any tie and any CAN dominant bit still in progress
                if (loader_init_done_in && uart_start) begin
                    state_next = BMS_UART;
                end else if (loader_init_done_in && can_valid) begin
                    state_next = BMS_CAN;
                end
            end
            BMS_USER, BMS_ALT, BMS_UART, BMS_CAN: state_next = state_reg;
            default: state_next = BMS_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= BMS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Received bytes go to internal RAM, wrapping at its size
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ram_ptr_reg <= '0;
            ram_wr_out <= '0;
        end else begin
            ram_wr_out.we <= 1'b0;
            if (link_up && load_valid_in) begin
                ram_wr_out.we <= 1'b1;
                ram_wr_out.addr <= ram_ptr_reg;
                ram_wr_out.data <= load_data_in;
                ram_ptr_reg <= ram_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            decided_reg <= 1'b0;
        end else begin
            decided_reg <= (state_reg != BMS_IDLE) && (state_reg != BMS_SCAN);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reserved_reg <= 1'b0;
        end else begin
            reserved_reg <= latched_reg && (strap_reg == `BMS_STRAP_RSVD);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fetch_boot_reg <= 1'b0;
        end else begin
            fetch_boot_reg <= in_loader;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            soft_reset_reg <= 1'b0;
        end else begin
            soft_reset_reg <= (state_reg == BMS_USER) && alt_strap;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            selective_reg <= 1'b0;
        end else begin
            selective_reg <= (state_reg != BMS_IDLE) && alt_strap && user_key_select_in
                && no_signature;
        end
    end

    // A normal reset keeps the watchdog alive even in the loader
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            watchdog_off_reg <= 1'b0;
        end else begin
            watchdog_off_reg <= !normal_reset_in && in_loader;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            uart_tx_oe_reg <= 1'b0;
            can_tx_oe_reg <= 1'b0;
        end else begin
            uart_tx_oe_reg <= (state_reg == BMS_UART);
            can_tx_oe_reg <= (state_reg == BMS_CAN);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            entry_reg <= '0;
        end else begin
            case (state_reg)
                BMS_USER: entry_reg <= `BMS_USER_ENTRY;
                BMS_ALT: entry_reg <= `BMS_ALT_ENTRY;
                BMS_SCAN, BMS_UART, BMS_CAN: begin
                    entry_reg <= alt_strap ? SELECT_ENTRY : LOADER_ENTRY;
                end
                default: entry_reg <= `BMS_USER_ENTRY;
            endcase
        end
    end

    assign boot_out = {entry_reg, fetch_boot_reg, soft_reset_reg, watchdog_off_reg,
        uart_tx_oe_reg, can_tx_oe_reg, selective_reg, reserved_reg};
    assign decided_out = decided_reg;
    assign straps_out = strap_reg;
endmodule : bms_boot_mode_selector
`default_nettype wire

// ===== dv/bms_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module bms_host_model (
    input wire logic clk_in,
    output logic uart0_receive_line_out,
    output logic can_port1_receive_line_out
);
    initial begin
        uart0_receive_line_out = 1'b1;
        can_port1_receive_line_out = 1'b1;
    end
    // Start bit held a whole bit time, then idle high again
    task automatic uart_start();
        @(posedge clk_in) uart0_receive_line_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        uart0_receive_line_out <= 1'b1;
    endtask : uart_start
    task automatic can_dom(input int n);
        @(posedge clk_in) can_port1_receive_line_out <= 1'b0;
        repeat (n) @(posedge clk_in);
        can_port1_receive_line_out <= 1'b1;
    endtask : can_dom
endmodule : bms_host_model
`default_nettype wire

// ===== dv/bms_boot_mode_selector_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module bms_checker
    import bms_pkg::*;
#(
    parameter logic [4:0] CAN_FILTER = 5'h14
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic reset_input_pin_in,
    input wire logic boot_select_upper_strap_in,
    input wire logic boot_select_lower_strap_in,
    input wire logic normal_reset_in,
    input wire logic user_sig_valid_in,
    input wire logic alt_sig_valid_in,
    input wire logic can_port1_receive_line_in,
    input wire logic load_valid_in,
    input wire logic [7:0] load_data_in,
    input wire bms_boot_t boot_out,
    input wire bms_ram_wr_t ram_wr_out,
    input wire logic [1:0] straps_out,
    input wire logic decided_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    logic [7:0] low_run;
    logic [7:0] last_low;
    // Length of the last finished dominant run, so a CAN pick can be judged
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_run <= 8'h00;
            last_low <= 8'h00;
        end else if (can_port1_receive_line_in) begin
            low_run <= 8'h00;
            if (low_run != 8'h00) begin
                last_low <= low_run;
            end
        end else if (low_run != 8'hFF) begin
            low_run <= low_run + 8'h01;
        end
    end
    a_strap_latch: assert property ($rose(reset_input_pin_in) |=>
        straps_out == {$past(boot_select_upper_strap_in), $past(boot_select_lower_strap_in)})
        else $error("straps not latched");
    a_user_map: assert property (decided_out && straps_out == 2'h3 |->
        boot_out.entry_addr == 24'h000000 && !boot_out.fetch_from_boot) else $error("user map");
    a_boot_fetch: assert property (boot_out.fetch_from_boot |->
        straps_out == 2'h2 || (straps_out == 2'h1 && !user_sig_valid_in && !alt_sig_valid_in))
        else $error("boot fetch");
    a_watchdog_off: assert property ($rose(boot_out.fetch_from_boot) |->
        boot_out.watchdog_off == !normal_reset_in) else $error("watchdog");
    a_soft_reset: assert property (decided_out && straps_out == 2'h1
        && user_sig_valid_in |-> boot_out.soft_reset && boot_out.entry_addr == 24'h000000)
        else $error("soft reset");
    a_alt_entry: assert property (decided_out && straps_out == 2'h1 && !user_sig_valid_in
        && alt_sig_valid_in |-> boot_out.entry_addr == 24'h090000) else $error("alt");
    a_reserved_idle: assert property (straps_out == 2'h0 |-> !decided_out)
        else $error("reserved");
    a_can_filter: assert property ($rose(boot_out.can_tx_oe) |->
        last_low >= {3'h0, CAN_FILTER}) else $error("short CAN pulse taken");
    a_ram_store: assert property (load_valid_in
        && (boot_out.uart_tx_oe || boot_out.can_tx_oe) |=> ram_wr_out.we
        && ram_wr_out.data == $past(load_data_in)) else $error("ram store");
    a_one_link: assert property (!(boot_out.uart_tx_oe && boot_out.can_tx_oe))
        else $error("both transmit pins driven");
    c_uart: cover property ($rose(boot_out.uart_tx_oe));
    c_can: cover property ($rose(boot_out.can_tx_oe));
    c_alt: cover property (boot_out.entry_addr == 24'h090000);
endmodule : bms_checker
bind bms_boot_mode_selector bms_checker #(.CAN_FILTER(CAN_FILTER)) u_chk (.*);
`default_nettype wire

// ===== dv/boot_mode_selector_tb.sv
`timescale 1ns/10ps
`default_nettype none
module boot_mode_selector_tb;
    import bms_pkg::*;
    logic clk_in = 0, rstn_in = 0, pin = 0, up = 0, lo = 0, nr = 0, us = 0, av = 0, key = 0;
    logic ini = 0, lv = 0, uart, can;
    logic [7:0] ld = 8'h00;
    bms_boot_t bo;
    bms_ram_wr_t rw;
    logic [1:0] so;
    logic dec;
    int err_count = 0, tests_run = 0;
    int q[$];
    always #2 clk_in = ~clk_in;
    bms_host_model HOST (.clk_in(clk_in), .uart0_receive_line_out(uart),
        .can_port1_receive_line_out(can));
    bms_boot_mode_selector DUT (.clk_in(clk_in), .rstn_in(rstn_in), .reset_input_pin_in(pin),
        .boot_select_upper_strap_in(up), .boot_select_lower_strap_in(lo), .normal_reset_in(nr),
        .user_sig_valid_in(us), .alt_sig_valid_in(av), .user_key_select_in(key),
        .loader_init_done_in(ini), .uart0_receive_line_in(uart), .can_port1_receive_line_in(can),
        .load_valid_in(lv), .load_data_in(ld), .boot_out(bo), .ram_wr_out(rw), .straps_out(so),
        .decided_out(dec));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t: seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict(input bit hung);
        if (hung) err_count++;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    // Reset is replayed per test because the mode holds until the next reset
    task automatic boot(input logic [1:0] s, input logic u, a, k, n);
        if (tests_run > 0) $display("test ends, checks %0d", tests_run);
        @(posedge clk_in);
        {rstn_in, pin, ini, up, lo, us, av, key, nr} <= {3'h0, s, u, a, k, n};
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in) pin <= 1'b1;
        repeat (6) @(negedge clk_in);
        chk(so, s);
    endtask : boot
    task automatic wait_oe();
        int i;
        for (i = 0; i < 300 && bo.uart_tx_oe !== 1'b1 && bo.can_tx_oe !== 1'b1; i++)
            @(negedge clk_in);
        if (i == 300) print_verdict(1);
    endtask : wait_oe
    initial begin
        void'($urandom(53));
        boot(2'h3, 0, 0, 0, 0);
        chk({bo.entry_addr, bo.fetch_from_boot, dec}, {24'h000000, 2'h1});
        boot(2'h1, 1, 1, 0, 0);
        chk({bo.entry_addr, bo.soft_reset}, {24'h000000, 1'b1});
        boot(2'h1, 0, 1, 0, 0);
        chk(bo.entry_addr, 24'h090000);
        boot(2'h1, 0, 0, 1, 0);
        chk(bo.selective, 1'b1);
        boot(2'h0, 1, 1, 1, 0);
        chk({bo.reserved_mode, dec}, 2'h2);
        boot(2'h2, 0, 0, 0, 0);
        chk({bo.entry_addr, bo.fetch_from_boot, bo.watchdog_off},
            {24'h000000, 2'h3});
        ini <= 1'b1;
        // UART start comes after a qualified CAN low but before it ends
        fork
            HOST.can_dom(30);
            begin
                repeat (24) @(posedge clk_in);
                HOST.uart_start();
            end
        join
        wait_oe();
        chk({bo.uart_tx_oe, bo.can_tx_oe}, 2'h2);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            q.push_back($urandom & 255);
            lv <= 1'b1;
            ld <= 8'(q[i]);
            @(posedge clk_in) lv <= 1'b0;
            @(negedge clk_in);
            chk({rw.we, rw.addr, rw.data}, {1'b1, 10'(i), 8'(q[i])});
        end
        boot(2'h2, 0, 0, 0, 1);
        chk(bo.watchdog_off, 1'b0);
        ini <= 1'b1;
        HOST.can_dom(12);
        repeat (30) @(negedge clk_in);
        chk(bo.can_tx_oe, 1'b0);
        HOST.can_dom(25);
        wait_oe();
        chk({bo.uart_tx_oe, bo.can_tx_oe}, 2'h1);
        $display("test ends, checks %0d", tests_run);
        print_verdict(0);
    end
endmodule : boot_mode_selector_tb
`default_nettype wire
